/* File: core/fpc_params.svh */
// Register map, field positions, command codes and bus timing of the flash command host
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH

`define FPC_CTRL_OFS     8'h00
`define FPC_ADDR_OFS     8'h04
`define FPC_DATA_OFS     8'h08
`define FPC_STATUS_OFS   8'h0c
`define FPC_RDATA_OFS    8'h10

`define FPC_CTRL_START   0
`define FPC_CTRL_OP_LSB  1
`define FPC_CTRL_BYPASS  5
`define FPC_CTRL_VPP     6
`define FPC_CTRL_RPIN    7
`define FPC_STAT_REFUSE  1
`define FPC_CTRL_RST     8'h00
`define FPC_ADDR_RST     23'h000000
`define FPC_DATA_RST     16'h0000

`define FPC_UNLOCK1_ADR  23'h000555
`define FPC_UNLOCK2_ADR  23'h0002aa
`define FPC_BANK_LOW     12'h555
`define FPC_CODE_AA      16'h00aa
`define FPC_CODE_55      16'h0055
`define FPC_CODE_PROG    16'h00a0
`define FPC_CODE_ERASE   16'h0080
`define FPC_CODE_CHIP    16'h0010
`define FPC_CODE_BLOCK   16'h0030
`define FPC_CODE_RESUME  16'h0030
`define FPC_CODE_SUSP    16'h00b0
`define FPC_CODE_QUERY   16'h0098
`define FPC_CODE_AUTO    16'h0090
`define FPC_CODE_RESET   16'h00f0
`define FPC_BUF_WORDS    32

`define FPC_CLK_NS       20
`define FPC_T_WE_NS      50
`define FPC_T_RD_NS      80
`define FPC_T_GAP_NS     30
`define FPC_WE_CYC       ((`FPC_T_WE_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_RD_CYC       ((`FPC_T_RD_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_GAP_CYC      ((`FPC_T_GAP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)

`endif

/* File: core/fpc_pkg.sv */
// Types shared by the flash command host
package fpc_pkg;
    typedef enum logic [3:0] {
        FPC_OP_READ, FPC_OP_RESET, FPC_OP_PROGRAM, FPC_OP_CHIP_ERASE,
        FPC_OP_BLOCK_ERASE, FPC_OP_BLOCK_ADD, FPC_OP_SUSPEND, FPC_OP_RESUME,
        FPC_OP_QUERY, FPC_OP_AUTOSEL, FPC_OP_BUF_SETUP, FPC_OP_BUF_LOAD,
        FPC_OP_BUF_CONFIRM, FPC_OP_POLL, FPC_OP_ABORT_RESET, FPC_OP_SPARE
    } fpc_op_t;

    typedef struct packed {
        logic [22:0] addr;
        logic [15:0] dq;
        logic        dqDriveN;
        logic        ceN;
        logic        oeN;
        logic        weN;
        logic        rpN;
        logic        highProgramVoltage;
    } fpc_pins_t;

    typedef struct packed {
        logic        isRead;
        logic [22:0] addr;
        logic [15:0] data;
    } fpc_cycle_t;
endpackage

/* File: core/fpc_host.sv */
// Flash command host: AXI4-Lite registers in, parallel flash bus cycles out
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fpc_params.svh"

module fpc_host #(
    parameter logic [15:0] BUF_SETUP_CODE   = 16'h0025, // Write-to-buffer setup code
    parameter logic [15:0] BUF_CONFIRM_CODE = 16'h0029  // Write-to-buffer confirm code
) (
    input  wire logic              sys_clk,    // 50 MHz clock
    input  wire logic              arst_n,     // Asynchronous reset, active low
    input  wire logic              clkEn,      // Freezes all state while low
    input  wire logic [7:0]        s_axi_awaddr,  // Write address
    input  wire logic              s_axi_awvalid, // Write address valid
    output logic                   s_axi_awready, // Write address ready
    input  wire logic [31:0]       s_axi_wdata,   // Write data
    input  wire logic [3:0]        s_axi_wstrb,   // Write byte strobes
    input  wire logic              s_axi_wvalid,  // Write data valid
    output logic                   s_axi_wready,  // Write data ready
    output logic [1:0]             s_axi_bresp,   // Write response
    output logic                   s_axi_bvalid,  // Write response valid
    input  wire logic              s_axi_bready,  // Write response ready
    input  wire logic [7:0]        s_axi_araddr,  // Read address
    input  wire logic              s_axi_arvalid, // Read address valid
    output logic                   s_axi_arready, // Read address ready
    output logic [31:0]            s_axi_rdata,   // Read data
    output logic [1:0]             s_axi_rresp,   // Read response
    output logic                   s_axi_rvalid,  // Read data valid
    input  wire logic              s_axi_rready,  // Read data ready
    output fpc_pkg::fpc_pins_t     flashOut,      // Flash bus outputs
    input  wire logic [15:0]       flashDqIn      // Flash data bus input
);
    import fpc_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_SETUP, ST_STROBE, ST_GAP} fpc_state_t;

    logic [7:0]  ctrlReg;
    logic [22:0] addrReg;
    logic [15:0] dataReg;
    logic [31:0] rdataReg;
    logic        refusedReg;
    logic [22:0] bufStartReg;
    logic [5:0]  bufLeftReg;
    logic        bufOpenReg;
    logic [7:0]  awAddrReg;
    logic [31:0] wDataReg;
    logic [3:0]  wStrbReg;
    logic        awHaveReg;
    logic        wHaveReg;
    fpc_state_t  stateReg;
    fpc_op_t     opReg;
    logic [2:0]  stepReg;
    logic [2:0]  timerReg;
    logic [2:0]  weCountReg;
    fpc_cycle_t  cyc;
    logic        bypass;
    logic        isLast;
    logic [2:0]  seqLen;
    logic        doWrite;
    logic        startReq;
    logic        loadOk;
    logic [22:0] bankQuery;
    logic [31:0] statusWord;

    // Bypass follows the software bit or the high voltage this host applies
    assign bypass    = ctrlReg[`FPC_CTRL_BYPASS] | ctrlReg[`FPC_CTRL_VPP];
    assign bankQuery = {addrReg[22:12], `FPC_BANK_LOW};

    function automatic logic [2:0] opLength(input fpc_op_t op, input logic byp);
        case (op)
            FPC_OP_PROGRAM:     opLength = byp ? 3'd2 : 3'd4;
            FPC_OP_CHIP_ERASE,
            FPC_OP_BLOCK_ERASE: opLength = 3'd6;
            FPC_OP_AUTOSEL,
            FPC_OP_ABORT_RESET: opLength = 3'd3;
            FPC_OP_BUF_SETUP:   opLength = byp ? 3'd2 : 3'd4;
            FPC_OP_POLL:        opLength = 3'd2;
            default:            opLength = 3'd1;
        endcase
    endfunction

    assign seqLen = opLength(opReg, bypass);
    assign isLast = (stepReg == seqLen - 3'd1);

    // One bus cycle of the current operation; bypass skips the two unlocks of program and buffer setup
    always_comb begin
        logic [2:0] e;
        e = stepReg;
        if ((opReg == FPC_OP_PROGRAM || opReg == FPC_OP_BUF_SETUP) && bypass) begin
            e = stepReg + 3'd2;
        end
        cyc = '{isRead: 1'b0, addr: addrReg, data: dataReg};
        case (opReg)
            FPC_OP_READ:  cyc.isRead = 1'b1;
            FPC_OP_POLL:  cyc.isRead = 1'b1;
            FPC_OP_RESET: cyc.data = `FPC_CODE_RESET;
            FPC_OP_BLOCK_ADD: cyc.data = `FPC_CODE_BLOCK;
            FPC_OP_SUSPEND:   cyc.data = `FPC_CODE_SUSP;
            FPC_OP_RESUME:    cyc.data = `FPC_CODE_RESUME;
            FPC_OP_QUERY:     cyc = '{1'b0, bankQuery, `FPC_CODE_QUERY};
            FPC_OP_BUF_LOAD:  cyc.data = dataReg;
            FPC_OP_BUF_CONFIRM: cyc.data = BUF_CONFIRM_CODE;
            default: begin
                case (e)
                    3'd0: cyc = '{1'b0, `FPC_UNLOCK1_ADR, `FPC_CODE_AA};
                    3'd1, 3'd4: cyc = '{1'b0, `FPC_UNLOCK2_ADR, `FPC_CODE_55};
                    3'd2: begin
                        case (opReg)
                            FPC_OP_PROGRAM: cyc = '{1'b0, `FPC_UNLOCK1_ADR, `FPC_CODE_PROG};
                            FPC_OP_AUTOSEL: cyc = '{1'b0, bankQuery, `FPC_CODE_AUTO};
                            FPC_OP_ABORT_RESET: cyc.data = `FPC_CODE_RESET;
                            FPC_OP_BUF_SETUP: cyc.data = BUF_SETUP_CODE;
                            default: cyc = '{1'b0, `FPC_UNLOCK1_ADR, `FPC_CODE_ERASE};
                        endcase
                    end
                    // Fourth cycle is the payload for program and setup, a fresh unlock for erase
                    3'd3: begin
                        case (opReg)
                            FPC_OP_PROGRAM:    cyc.data = dataReg;
                            FPC_OP_BUF_SETUP:  cyc.data = dataReg;
                            default:           cyc = '{1'b0, `FPC_UNLOCK1_ADR, `FPC_CODE_AA};
                        endcase
                    end
                    default: begin
                        case (opReg)
                            FPC_OP_CHIP_ERASE: begin
                                cyc.addr = `FPC_UNLOCK1_ADR;
                                cyc.data = `FPC_CODE_CHIP;
                            end
                            default:           cyc.data = `FPC_CODE_BLOCK;
                        endcase
                    end
                endcase
            end
        endcase
    end

    // Host-side guards keep the device from ever seeing a sequence it would abort on
    assign loadOk = bufOpenReg && bufLeftReg != 6'd0
                 && addrReg[22:5] == bufStartReg[22:5]
                 && addrReg >= bufStartReg;

    // AXI4-Lite write side
    assign s_axi_awready = clkEn && !awHaveReg && !s_axi_bvalid;
    assign s_axi_wready  = clkEn && !wHaveReg && !s_axi_bvalid;
    assign doWrite       = awHaveReg && wHaveReg && !s_axi_bvalid;
    assign startReq      = doWrite && awAddrReg == `FPC_CTRL_OFS && wStrbReg[0]
                         && wDataReg[`FPC_CTRL_START];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            awHaveReg <= 1'b0;
            wHaveReg  <= 1'b0;
            awAddrReg <= 8'h00;
            wDataReg  <= 32'h0000_0000;
            wStrbReg  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHaveReg <= 1'b1;
                awAddrReg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHaveReg <= 1'b1;
                wDataReg <= s_axi_wdata;
                wStrbReg <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHaveReg    <= 1'b0;
                wHaveReg     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddrReg <= `FPC_STATUS_OFS && awAddrReg[1:0] == 2'b00)
                              ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software registers; a start while busy is refused and not queued
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlReg <= `FPC_CTRL_RST;
            addrReg <= `FPC_ADDR_RST;
            dataReg <= `FPC_DATA_RST;
        end else if (clkEn && doWrite && stateReg == ST_IDLE) begin
            if (awAddrReg == `FPC_CTRL_OFS && wStrbReg[0]) begin
                ctrlReg <= wDataReg[7:0] & ~8'h01;
            end
            if (awAddrReg == `FPC_ADDR_OFS) begin
                addrReg <= wDataReg[22:0];
            end
            if (awAddrReg == `FPC_DATA_OFS) begin
                dataReg <= wDataReg[15:0];
            end
        end
    end

    // Sticky refusal flag: a new refusal wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            refusedReg <= 1'b0;
        end else if (clkEn) begin
            if ((startReq && stateReg != ST_IDLE)
                || (stateReg == ST_CHECK && (opReg == FPC_OP_BUF_SETUP
                    ? dataReg > 16'(`FPC_BUF_WORDS - 1)
                    : opReg == FPC_OP_BUF_LOAD ? !loadOk
                    : opReg == FPC_OP_BUF_CONFIRM && (!bufOpenReg || bufLeftReg != 6'd0)))) begin
                refusedReg <= 1'b1;
            end else if (doWrite && awAddrReg == `FPC_STATUS_OFS
                         && wDataReg[`FPC_STAT_REFUSE]) begin
                refusedReg <= 1'b0;
            end
        end
    end

    // Bus cycle sequencer
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stateReg   <= ST_IDLE;
            opReg      <= FPC_OP_READ;
            stepReg    <= 3'd0;
            timerReg   <= 3'd0;
            weCountReg <= 3'd0;
        end else if (clkEn) begin
            case (stateReg)
                ST_IDLE: begin
                    // The word being written decides, so a start with the reset hold is dropped
                    if (startReq && !wDataReg[`FPC_CTRL_RPIN]) begin
                        opReg      <= fpc_op_t'(wDataReg[`FPC_CTRL_OP_LSB +: 4]);
                        stepReg    <= 3'd0;
                        weCountReg <= 3'd0;
                        stateReg   <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if ((opReg == FPC_OP_BUF_SETUP && dataReg > 16'(`FPC_BUF_WORDS - 1))
                        || (opReg == FPC_OP_BUF_LOAD && !loadOk)
                        || (opReg == FPC_OP_BUF_CONFIRM
                            && (!bufOpenReg || bufLeftReg != 6'd0))) begin
                        stateReg <= ST_IDLE;
                    end else begin
                        stateReg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    timerReg <= cyc.isRead ? 3'(`FPC_RD_CYC - 1) : 3'(`FPC_WE_CYC - 1);
                    stateReg <= ST_STROBE;
                    if (!cyc.isRead) begin
                        weCountReg <= weCountReg + 3'd1;
                    end
                end
                ST_STROBE: begin
                    if (timerReg == 3'd0) begin
                        timerReg <= 3'(`FPC_GAP_CYC - 1);
                        stateReg <= ST_GAP;
                    end else begin
                        timerReg <= timerReg - 3'd1;
                    end
                end
                ST_GAP: begin
                    if (timerReg != 3'd0) begin
                        timerReg <= timerReg - 3'd1;
                    end else if (isLast) begin
                        stateReg <= ST_IDLE;
                    end else begin
                        stepReg  <= stepReg + 3'd1;
                        stateReg <= ST_SETUP;
                    end
                end
                default: stateReg <= ST_IDLE;
            endcase
        end
    end

    // Write buffer bookkeeping mirrors the device's load counter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bufStartReg <= 23'h000000;
            bufLeftReg  <= 6'd0;
            bufOpenReg  <= 1'b0;
        end else if (clkEn && stateReg == ST_GAP && timerReg == 3'd0 && isLast) begin
            case (opReg)
                FPC_OP_BUF_SETUP: begin
                    bufStartReg <= addrReg;
                    bufLeftReg  <= 6'(dataReg[4:0]) + 6'd1;
                    bufOpenReg  <= 1'b1;
                end
                FPC_OP_BUF_LOAD: bufLeftReg <= bufLeftReg - 6'd1;
                FPC_OP_BUF_CONFIRM,
                FPC_OP_ABORT_RESET,
                FPC_OP_RESET: bufOpenReg <= 1'b0;
                default: ;
            endcase
        end
    end

    // Sample the data bus at the end of the read strobe; poll keeps both reads
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdataReg <= 32'h0000_0000;
        end else if (clkEn && stateReg == ST_STROBE && timerReg == 3'd0 && cyc.isRead) begin
            if (stepReg == 3'd0) begin
                rdataReg <= {16'h0000, flashDqIn};
            end else begin
                rdataReg[31:16] <= flashDqIn;
            end
        end
    end

    // Flash pins come straight from flops or registered state
    always_comb begin
        flashOut.addr     = cyc.addr;
        flashOut.dq       = cyc.data;
        flashOut.dqDriveN = !(stateReg inside {ST_SETUP, ST_STROBE, ST_GAP}) || cyc.isRead;
        flashOut.ceN      = !(stateReg inside {ST_SETUP, ST_STROBE});
        flashOut.oeN      = !(stateReg == ST_STROBE && cyc.isRead);
        flashOut.weN      = !(stateReg == ST_STROBE && !cyc.isRead);
        flashOut.rpN      = !ctrlReg[`FPC_CTRL_RPIN];
        flashOut.highProgramVoltage = ctrlReg[`FPC_CTRL_VPP];
    end

    // Status: toggle from the two poll reads, abort and timeout from the first one
    assign statusWord = {18'h00000, rdataReg[22] ^ rdataReg[6], rdataReg[7], rdataReg[5],
                         rdataReg[1], bufOpenReg, bufLeftReg, bypass, refusedReg,
                         stateReg != ST_IDLE};

    // AXI4-Lite read side
    assign s_axi_arready = clkEn && !s_axi_rvalid;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case (s_axi_araddr)
                    `FPC_CTRL_OFS:   s_axi_rdata <= {24'h000000, ctrlReg};
                    `FPC_ADDR_OFS:   s_axi_rdata <= {9'h000, addrReg};
                    `FPC_DATA_OFS:   s_axi_rdata <= {16'h0000, dataReg};
                    `FPC_STATUS_OFS: s_axi_rdata <= statusWord;
                    `FPC_RDATA_OFS:  s_axi_rdata <= rdataReg;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n || !clkEn);

    logic seqDone;
    assign seqDone = stateReg == ST_GAP && timerReg == 3'd0 && isLast;

    chk_prog_length: assert property (seqDone && opReg == FPC_OP_PROGRAM && !bypass
        |-> weCountReg == 3'd4) else $error("program not four writes");
    chk_prog_data: assert property (seqDone && opReg == FPC_OP_PROGRAM
        |-> flashOut.addr == addrReg && flashOut.dq == dataReg) else $error("program payload wrong");
    chk_unlock_first: assert property (stateReg == ST_STROBE && !flashOut.weN
        && opReg == FPC_OP_PROGRAM && !bypass && stepReg == 3'd0
        |-> flashOut.addr == 23'h000555 && flashOut.dq == 16'h00aa) else $error("bad first unlock");
    chk_reset_code: assert property (!flashOut.weN && opReg == FPC_OP_RESET
        |-> flashOut.dq == 16'h00f0) else $error("reset code wrong");
    chk_rp_quiet: assert property (!flashOut.rpN
        |-> flashOut.weN && flashOut.oeN) else $error("strobe during reset");
    chk_chip_length: assert property (seqDone && opReg == FPC_OP_CHIP_ERASE
        |-> weCountReg == 3'd6 && flashOut.dq == 16'h0010) else $error("chip erase wrong");
    chk_bypass_skip: assert property (seqDone && opReg == FPC_OP_PROGRAM && bypass
        |-> weCountReg == 3'd2) else $error("bypass not two writes");
    chk_query_code: assert property (!flashOut.weN && opReg == FPC_OP_QUERY
        |-> flashOut.dq == 16'h0098 && flashOut.addr[11:0] == 12'h555) else $error("query wrong");
    chk_count_refuse: assert property (stateReg == ST_CHECK && opReg == FPC_OP_BUF_SETUP
        && dataReg > 16'd31 |=> stateReg == ST_IDLE && refusedReg) else $error("oversize count sent");
    chk_load_page: assert property (!flashOut.weN && opReg == FPC_OP_BUF_LOAD
        |-> flashOut.addr[22:5] == bufStartReg[22:5]) else $error("load off page");
    chk_we_width: assert property ($fell(flashOut.weN)
        |-> (!flashOut.weN)[*3] ##1 flashOut.weN) else $error("write strobe width");
    chk_drive_write: assert property (!flashOut.weN
        |-> !flashOut.dqDriveN && !flashOut.ceN) else $error("write without drive");

    cov_program: cover property (seqDone && opReg == FPC_OP_PROGRAM);
    cov_buf_confirm: cover property (seqDone && opReg == FPC_OP_BUF_CONFIRM);
    cov_poll: cover property (seqDone && opReg == FPC_OP_POLL);
endmodule

/* File: verif/fpc_dev_model.sv */
// Behavioural flash device seen from the host's bus pins
`timescale 1ns/1ps
module fpc_dev_model (
    input  wire fpc_pkg::fpc_pins_t pins,  // Bus pins from the host
    output logic [15:0]             dqOut  // Data bus towards the host
);
    import fpc_pkg::*;
    logic [22:0] wa [0:15];
    logic [15:0] wd [0:15];
    int          wn = 0;
    // Address and data are stable from setup, so capture at the strobe start
    always @(negedge pins.weN) begin
        if (!pins.ceN && pins.rpN && wn < 16) begin
            wa[wn] = pins.addr;
            wd[wn] = pins.dq;
            wn = wn + 1;
        end
    end
    // Released bus shows the inverse so a stale sample cannot pass
    assign dqOut = (!pins.ceN && !pins.oeN) ? (pins.addr[15:0] ^ 16'h00ff)
                                            : ~(pins.addr[15:0] ^ 16'h00ff);
endmodule

/* File: verif/tb_top.sv */
// Register-level testbench for the flash command host
`timescale 1ns/1ps
`include "fpc_params.svh"
module tb_top;
    import fpc_pkg::*;
    logic        sysClk = 0, arstN = 0, awv = 0, wv = 0, arv = 0;
    logic [7:0]  aw = 0, ar = 0;
    logic [31:0] wdat = 0, rdat, rd, st;
    logic [1:0]  br, rr, rs;
    logic        awr, wr, bv, arr, rv;
    fpc_pins_t   pins;
    logic [15:0] dqIn;
    int          miscompares = 0, total_checks = 0, cyc = 0;
    always #10 sysClk = ~sysClk;
    fpc_host u_dut (.sys_clk(sysClk), .arst_n(arstN), .clkEn(1'b1), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdat), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .flashOut(pins), .flashDqIn(dqIn));
    fpc_dev_model u_dev (.pins(pins), .dqOut(dqIn));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge sysClk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            complete_run;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkw(input int i, input logic [22:0] a, input logic [15:0] d);
        chk("addr", {9'h0, a}, {9'h0, u_dev.wa[i]});
        chk("data", {16'h0, d}, {16'h0, u_dev.wd[i]});
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aDone, wDone;
        aDone = 0;
        wDone = 0;
        aw <= a; wdat <= d; awv <= 1; wv <= 1;
        while (!(aDone && wDone)) begin
            @(posedge sysClk);
            if (!aDone && awr) begin
                aDone = 1;
                awv <= 0;
            end
            if (!wDone && wr) begin
                wDone = 1;
                wv <= 0;
            end
        end
        while (bv !== 1'b1) @(posedge sysClk);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        ar <= a; arv <= 1;
        do @(posedge sysClk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge sysClk); while (rv !== 1'b1);
        d = rdat; r = rr;
    endtask
    task automatic op(input logic [3:0] o, input logic [22:0] a, input logic [15:0] d,
                      input logic [1:0] m);
        u_dev.wn = 0;
        axw(`FPC_ADDR_OFS, {9'h0, a});
        axw(`FPC_DATA_OFS, {16'h0, d});
        axw(`FPC_CTRL_OFS, {24'h0, 1'b0, m, o, 1'b1});
        do axr(`FPC_STATUS_OFS, st, rs); while (st[0] !== 1'b0);
        $display("op %0d done", o);
    endtask
    initial begin
        repeat (4) @(posedge sysClk);
        arstN <= 1;
        @(posedge sysClk);
        op(4'd2, 23'h012345, 16'h1234, 2'b00);
        chk("count", 4, u_dev.wn);
        chkw(0, `FPC_UNLOCK1_ADR, `FPC_CODE_AA);
        chkw(1, `FPC_UNLOCK2_ADR, `FPC_CODE_55);
        chkw(2, `FPC_UNLOCK1_ADR, `FPC_CODE_PROG);
        chkw(3, 23'h012345, 16'h1234);
        op(4'd2, 23'h000100, 16'h00ff, 2'b01);
        chk("count", 2, u_dev.wn);
        chkw(0, `FPC_UNLOCK1_ADR, `FPC_CODE_PROG);
        op(4'd2, 23'h000101, 16'h0f0f, 2'b10);
        chk("count", 2, u_dev.wn);
        chk("bypass", 1, st[2]);
        op(4'd3, 23'h0, 16'h0, 2'b00);
        chk("count", 6, u_dev.wn);
        chkw(3, `FPC_UNLOCK1_ADR, `FPC_CODE_AA);
        chkw(5, `FPC_UNLOCK1_ADR, `FPC_CODE_CHIP);
        op(4'd4, 23'h040000, 16'h0, 2'b00);
        chkw(5, 23'h040000, `FPC_CODE_BLOCK);
        op(4'd5, 23'h080000, 16'h0, 2'b00);
        chkw(0, 23'h080000, `FPC_CODE_BLOCK);
        op(4'd6, 23'h400000, 16'h0, 2'b00);
        chkw(0, 23'h400000, `FPC_CODE_SUSP);
        op(4'd7, 23'h400000, 16'h0, 2'b00);
        chkw(0, 23'h400000, `FPC_CODE_RESUME);
        op(4'd8, 23'h400123, 16'h0, 2'b00);
        chkw(0, 23'h400555, `FPC_CODE_QUERY);
        op(4'd9, 23'h400000, 16'h0, 2'b00);
        chkw(2, 23'h400555, `FPC_CODE_AUTO);
        op(4'd1, 23'h0, 16'h0, 2'b00);
        chk("reset", `FPC_CODE_RESET, u_dev.wd[0]);
        op(4'd10, 23'h010000, 16'd32, 2'b00);
        chk("count", 0, u_dev.wn);
        chk("refused", 1, st[1]);
        axw(`FPC_STATUS_OFS, 32'h0000_0002);
        axr(`FPC_STATUS_OFS, st, rs);
        chk("refused", 0, st[1]);
        op(4'd10, 23'h010000, 16'd1, 2'b00);
        chkw(3, 23'h010000, 16'h0001);
        op(4'd12, 23'h010000, 16'h0, 2'b00);
        chk("count", 0, u_dev.wn);
        op(4'd11, 23'h010000, 16'h1111, 2'b00);
        chkw(0, 23'h010000, 16'h1111);
        op(4'd11, 23'h010020, 16'h3333, 2'b00);
        chk("count", 0, u_dev.wn);
        op(4'd11, 23'h010001, 16'h2222, 2'b00);
        op(4'd12, 23'h010000, 16'h0, 2'b00);
        chkw(0, 23'h010000, 16'h0029);
        op(4'd13, 23'h000777, 16'h0, 2'b00);
        axr(`FPC_RDATA_OFS, rd, rs);
        chk("poll", 32'h07880788, rd);
        chk("pollstat", 4'b0100, st[13:10]);
        axr(8'h1c, rd, rs);
        chk("resp", 2, rs);
        op(4'd14, 23'h010000, 16'h0, 2'b00);
        chkw(2, 23'h010000, `FPC_CODE_RESET);
        op(4'd0, 23'h000123, 16'h0, 2'b00);
        axr(`FPC_RDATA_OFS, rd, rs);
        chk("read", 32'h000001dc, rd);
        u_dev.wn = 0;
        axw(`FPC_CTRL_OFS, 32'h0000_0085);
        axr(`FPC_STATUS_OFS, st, rs);
        chk("rpbusy", 0, st[0]);
        chk("rppin", 0, pins.rpN);
        chk("count", 0, u_dev.wn);
        axw(`FPC_CTRL_OFS, 32'h0000_0000);
        chk("rppin", 1, pins.rpN);
        $display("reset hold done");
        complete_run;
    end
endmodule
